// ### hdl/pse_encoder.sv
// multiplexer scanner, successive-approximation converter and word holding register
`default_nettype none
module pse_encoder
  import pse_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic             encode_cmd,
  input  wire logic             transfer_pulse,
  input  wire logic             encoder_inhibit,
  input  wire logic [1:0]       mode_cmd,
  input  wire logic             cmp_keep,
  output logic [NUM_MUX-1:0]    mux_gate,
  output logic [RES_W-1:0]      dac_trial,
  output logic [RES_W-1:0]      adc_result,
  output logic                  conv_busy,
  output logic                  conv_done,
  output logic [RES_W-1:0]      word_holding_register
);

  // one-hot weight of a result bit
  function automatic logic [RES_W-1:0] bit_weight(input logic [3:0] idx);
    bit_weight = RES_W'(1) << idx;
  endfunction : bit_weight

  // scanner gate pattern for a mode and slot
  function automatic logic [NUM_MUX-1:0] gate_of(input logic [1:0] m, input logic [2:0] s);
    gate_of = NUM_MUX'(1) << SCAN_PATCH[m][s];
  endfunction : gate_of

  typedef struct packed {
    logic [6:0]       div;
    pse_conv_t        conv;
    logic [3:0]       step;
    logic [3:0]       bit_idx;
    logic [RES_W-1:0] trial;
    logic [RES_W-1:0] sar;
    logic             done;
    logic [RES_W-1:0] hold;
    logic [1:0]       mode;
    logic [2:0]       slot;
  } pse_state_t;

  pse_state_t st_r;
  pse_state_t st_nxt;
  logic       adc_tick;
  logic       start;
  logic [1:0] mode_req;
  logic [RES_W-1:0] sar_keep;

  // mode 0 needs no command; the higher command line wins
  assign mode_req = mode_cmd[1] ? 2'h2 : (mode_cmd[0] ? 2'h1 : 2'h0);
  // divider never restarts on encode, so the tick is free-running
  assign adc_tick = (st_r.div == DIV_LAST);
  // an encode during a conversion is ignored; one per word is expected
  assign start    = encode_cmd && (st_r.conv == PSE_IDLE);
  assign sar_keep = cmp_keep ? st_r.trial : st_r.sar;

  // next-state logic for divider, converter, scanner and holding register
  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.div = adc_tick ? 7'h00 : st_r.div + 7'h01;
    case (st_r.conv)
      PSE_IDLE:
      begin
        if (start)
        begin
          st_nxt.conv    = PSE_CONV;
          st_nxt.step    = 4'h0;
          st_nxt.bit_idx = MSB_IDX;
          st_nxt.sar     = RES_RST;
          st_nxt.trial   = bit_weight(MSB_IDX);
          st_nxt.done    = 1'b0;
        end
      end
      PSE_CONV:
      begin
        if (adc_tick)
        begin
          st_nxt.step = st_r.step + 4'h1;
          // steps 1..10 decide bits, the rest are settle and latch
          if (st_r.step != 4'h0 && st_r.step <= 4'(RES_W))
          begin
            st_nxt.sar = sar_keep;
            if (st_r.bit_idx != 4'h0)
            begin
              st_nxt.bit_idx = st_r.bit_idx - 4'h1;
              st_nxt.trial   = sar_keep | bit_weight(st_r.bit_idx - 4'h1);
            end
            else
            begin
              st_nxt.trial = sar_keep;
            end
          end
          if (st_r.step == STEP_LAST - 4'h1)
          begin
            st_nxt.conv = PSE_IDLE;
            st_nxt.done = 1'b1;
          end
        end
      end
      default:
      begin
        st_nxt.conv = PSE_IDLE;
      end
    endcase
    // word-end transfer: load holding register unless encoder_inhibit and, if the converter is idle, step the scanner on the same edge
    if (transfer_pulse)
    begin
      if (!encoder_inhibit)
      begin
        st_nxt.hold = st_r.sar;
      end
      if (st_r.conv == PSE_IDLE)
      begin
        if (mode_req != st_r.mode)
        begin
          st_nxt.mode = mode_req;
          st_nxt.slot = SLOT_RST;
        end
        else if (st_r.slot == SCAN_LAST[st_r.mode])
        begin
          st_nxt.slot = SLOT_RST;
        end
        else
        begin
          st_nxt.slot = st_r.slot + 3'h1;
        end
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_r <= '{div: 7'h00, conv: PSE_IDLE, step: 4'h0, bit_idx: MSB_IDX,
                trial: RES_RST, sar: RES_RST, done: 1'b0, hold: RES_RST,
                mode: MODE_RST, slot: SLOT_RST};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign mux_gate              = gate_of(st_r.mode, st_r.slot);
  assign dac_trial             = st_r.trial;
  assign adc_result            = st_r.sar;
  assign conv_busy             = (st_r.conv == PSE_CONV);
  assign conv_done             = st_r.done;
  assign word_holding_register = st_r.hold;

  // helper: cycles spent in the current conversion
  logic [11:0] busy_cyc_r;
  always_ff @(posedge ref_clk)
  begin
    if (srst || start)
    begin
      busy_cyc_r <= 12'h000;
    end
    else if (conv_busy)
    begin
      busy_cyc_r <= busy_cyc_r + 12'h001;
    end
  end

  sequence seq_start;
    encode_cmd && !conv_busy;
  endsequence
  sequence seq_loaded;
    conv_busy && !conv_done && (adc_result == RES_RST) && (dac_trial == 10'h0200);
  endsequence

  chk_gate_onehot: assert property (@(posedge ref_clk) disable iff (srst)
    $onehot(mux_gate)) else $error("scanner gate not one-hot");
  chk_encode_clears: assert property (@(posedge ref_clk) disable iff (srst)
    seq_start |=> seq_loaded) else $error("encode did not clear and start msb trial");
  chk_scan_frozen: assert property (@(posedge ref_clk) disable iff (srst)
    conv_busy |=> $stable(st_r.mode) && $stable(st_r.slot))
    else $error("scanner moved during conversion");
  chk_result_holds: assert property (@(posedge ref_clk) disable iff (srst)
    conv_done && !encode_cmd |=> $stable(adc_result) && conv_done)
    else $error("held result changed before encode");
  chk_hold_inhibit: assert property (@(posedge ref_clk) disable iff (srst)
    transfer_pulse && encoder_inhibit |=> $stable(word_holding_register))
    else $error("inhibited transfer loaded holding register");
  chk_hold_load: assert property (@(posedge ref_clk) disable iff (srst)
    transfer_pulse && !encoder_inhibit |=> word_holding_register == $past(adc_result))
    else $error("transfer did not load converter result");
  chk_conv_length: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(conv_busy) |-> busy_cyc_r >= 12'h514 && busy_cyc_r <= 12'h578)
    else $error("conversion length outside 13 to 14 ticks");
  chk_tick_paced: assert property (@(posedge ref_clk) disable iff (srst)
    conv_busy && !adc_tick |=> $stable(dac_trial) && $stable(adc_result))
    else $error("converter stepped without a tick");
  chk_mode_switch: assert property (@(posedge ref_clk) disable iff (srst)
    transfer_pulse && !conv_busy && mode_req != st_r.mode
    |=> st_r.slot == SLOT_RST && st_r.mode == $past(mode_req))
    else $error("mode change did not restart sequence");
  chk_done_clean: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(conv_done) |-> !conv_busy && $past(conv_busy))
    else $error("done rose without a finished conversion");

endmodule : pse_encoder
`default_nettype wire

// ### hdl/pse_pkg.sv
// constants and types for the sample scanner and converter front end
`default_nettype none
package pse_pkg;
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned ADC_HZ      = 250_000;
  localparam int unsigned ADC_DIV     = CLK_HZ / ADC_HZ;
  localparam int unsigned CONV_TIME_US = 56;
  // longest time, so the step count rounds down
  localparam int unsigned CONV_STEPS  = (CONV_TIME_US * ADC_HZ) / 1_000_000;
  localparam int unsigned RES_W       = 10;
  localparam int unsigned NUM_MUX     = 6;
  localparam int unsigned NUM_MODES   = 3;
  localparam int unsigned SEQ_LEN     = 6;
  localparam logic [3:0]  MSB_IDX     = 4'h9;
  localparam logic [6:0]  DIV_LAST    = 7'(ADC_DIV - 1);
  localparam logic [3:0]  STEP_LAST   = 4'(CONV_STEPS);
  localparam logic [RES_W-1:0] RES_RST = 10'h000;
  localparam logic [1:0]  MODE_RST    = 2'h0;
  localparam logic [2:0]  SLOT_RST    = 3'h0;
  // scan patch: per mode, the multiplexer index for each slot
  localparam logic [NUM_MODES-1:0][SEQ_LEN-1:0][2:0] SCAN_PATCH = {
    {3'h0, 3'h3, 3'h0, 3'h2, 3'h0, 3'h1},
    {3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0},
    {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0}
  };
  // last slot of each mode's sequence
  localparam logic [NUM_MODES-1:0][2:0] SCAN_LAST = {3'h5, 3'h1, 3'h5};
  typedef enum logic {PSE_IDLE, PSE_CONV} pse_conv_t;
endpackage : pse_pkg
`default_nettype wire

// ### verification/pse_mux_model.sv
// analog multiplexer trains seen through the scanner by the comparator
`default_nettype none
module pse_mux_model
  import pse_pkg::*;
(
  input  wire logic [NUM_MUX-1:0]            mux_gate,
  input  wire logic [RES_W-1:0]              dac_trial,
  input  wire logic [NUM_MUX-1:0][RES_W-1:0] level,
  output logic                               cmp_keep
);
  timeunit 1ns;
  timeprecision 1ps;
  // an ungated path reads as zero volts, so a dead gate loses every bit
  always_comb
  begin
    cmp_keep = 1'b0;
    for (int i = 0; i < NUM_MUX; i++)
      if (mux_gate[i] && level[i] >= dac_trial)
        cmp_keep = 1'b1;
  end
endmodule : pse_mux_model
`default_nettype wire

// ### verification/pse_encoder_tb.sv
// self-checking bench for the scanner and converter front end
`default_nettype none
module pse_encoder_tb
  import pse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, srst, encode_cmd, transfer_pulse, encoder_inhibit, cmp_keep;
  logic conv_busy, conv_done, done_q;
  logic [1:0] mode_cmd;
  logic [NUM_MUX-1:0] mux_gate;
  logic [RES_W-1:0] dac_trial, adc_result, whr;
  logic [NUM_MUX-1:0][RES_W-1:0] lv;
  logic [RES_W-1:0] exp_q[$];
  logic [1:0] md;
  logic [2:0] sl;
  int n_fail, compares;

  pse_encoder dut (.ref_clk(ref_clk), .srst(srst), .encode_cmd(encode_cmd),
    .transfer_pulse(transfer_pulse), .encoder_inhibit(encoder_inhibit),
    .mode_cmd(mode_cmd), .cmp_keep(cmp_keep), .mux_gate(mux_gate), .dac_trial(dac_trial),
    .adc_result(adc_result), .conv_busy(conv_busy), .conv_done(conv_done),
    .word_holding_register(whr));
  pse_mux_model model (.mux_gate(mux_gate), .dac_trial(dac_trial), .level(lv),
    .cmp_keep(cmp_keep));

  task automatic chk(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // converter codes and trial words
  task automatic chk_code(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
    chk(got, exp);
  endtask : chk_code

  // holding register after a transfer
  task automatic chk_hold(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
    chk(got, exp);
  endtask : chk_hold

  // scanner gate pattern
  task automatic chk_gate(input logic [NUM_MUX-1:0] got, input logic [NUM_MUX-1:0] exp);
    chk(RES_W'(got), RES_W'(exp));
  endtask : chk_gate

  // busy and done flags, busy in the upper bit
  task automatic chk_flags(input logic [1:0] got, input logic [1:0] exp);
    chk(RES_W'(got), RES_W'(exp));
  endtask : chk_flags

  // encode-to-done edges: first tick lands 1..ADC_DIV edges away, the rest are whole ticks
  task automatic chk_time(input int got);
    int lo, hi;
    lo = int'(ADC_DIV * (STEP_LAST - 4'h1)) + 1;
    hi = int'(ADC_DIV * STEP_LAST);
    chk(RES_W'(got >= lo && got <= hi), 10'h001);
  endtask : chk_time

  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // one word: encode, maybe a refused second encode, then transfer
  task automatic word(input logic [1:0] mc, input logic inh, input logic twice);
    logic [2:0] mx;
    logic [1:0] rq;
    logic [RES_W-1:0] e, old;
    int i;
    mx = SCAN_PATCH[md][sl];
    chk_gate(mux_gate, NUM_MUX'(1) << mx);
    e = 10'($urandom_range(1023));
    lv[mx] <= e;
    mode_cmd <= mc;
    exp_q.push_back(e);
    @(posedge ref_clk);
    encode_cmd <= 1'b1;
    @(posedge ref_clk);
    encode_cmd <= twice;
    @(posedge ref_clk);
    encode_cmd <= 1'b0;
    // values read here are those launched by the accepted encode edge
    chk_flags({conv_busy, conv_done}, 2'h2);
    chk_code(adc_result, RES_RST);
    chk_code(dac_trial, RES_W'(1) << MSB_IDX);
    i = 0;
    while (conv_done !== 1'b1 && i < 1500)
    begin
      @(posedge ref_clk);
      i++;
    end
    chk_time(i);
    chk_flags({conv_busy, conv_done}, 2'h1);
    old = whr;
    encoder_inhibit <= inh;
    transfer_pulse <= 1'b1;
    @(posedge ref_clk);
    transfer_pulse <= 1'b0;
    @(negedge ref_clk);
    chk_hold(whr, inh ? old : e);
    rq = mc[1] ? 2'h2 : (mc[0] ? 2'h1 : 2'h0);
    if (rq != md)
    begin
      md = rq;
      sl = 3'h0;
    end
    else
      sl = (sl == SCAN_LAST[md]) ? 3'h0 : sl + 3'h1;
    @(posedge ref_clk);
  endtask : word

  // oldest expected code is compared as each conversion finishes
  always @(posedge ref_clk)
  begin
    done_q <= conv_done;
    if (conv_done === 1'b1 && done_q !== 1'b1)
      chk_code(adc_result, exp_q.pop_front());
  end

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // four mode settings; counts chosen so every sequence wraps once
  // the last two settings share the third sequence and walk all six slots
  initial
  begin
    int nw[4];
    nw = '{7, 3, 4, 4};
    {srst, encode_cmd, transfer_pulse, encoder_inhibit} = 4'h8;
    mode_cmd = 2'h0;
    md = 2'h0;
    sl = 3'h0;
    void'($urandom(39944));
    for (int i = 0; i < NUM_MUX; i++)
      lv[i] = 10'($urandom_range(1023));
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    for (int m = 0; m < 4; m++)
    begin
      for (int k = 0; k < nw[m]; k++)
        word(2'(m), 1'($urandom_range(3) == 0), 1'(k[0]));
      $display("mode command %0d test done", m);
    end
    final_report();
  end

  // hang guard well beyond eighteen words of about 1410 cycles
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    final_report();
  end
endmodule : pse_encoder_tb
`default_nettype wire
